// ===== snp_cfg.svh
// register offsets, field positions, reset values and timing constants
// for the serial-to-network packer; included by the design and its bench
`ifndef SNP_CFG_SVH
`define SNP_CFG_SVH

// apb byte addresses, one aligned word each
`define SNP_PACK_TIME_ADDR 8'h00
`define SNP_PACK_SIZE_ADDR 8'h04
`define SNP_PACK_CHAR_ADDR 8'h08
`define SNP_INACT_TIME_ADDR 8'h0c
`define SNP_STATUS_ADDR 8'h10
`define SNP_INT_STAT_ADDR 8'h14
`define SNP_INT_MASK_ADDR 8'h18

// reset values: every delimiter and the inactivity close disabled
`define SNP_PACK_TIME_RST 16'h0000
`define SNP_PACK_SIZE_RST 16'h0000
`define SNP_PACK_CHAR_RST 8'h00
`define SNP_INACT_TIME_RST 16'h0000
`define SNP_INT_MASK_RST 4'h0

// status register fields
`define SNP_STAT_CONN_BIT 0
`define SNP_STAT_SEND_BIT 1
`define SNP_STAT_COUNT_LSB 16

// interrupt status / mask bits
`define SNP_EV_PKT_BIT 0
`define SNP_EV_ACCEPT_BIT 1
`define SNP_EV_REFUSE_BIT 2
`define SNP_EV_INACT_BIT 3
`define SNP_EV_NUM 4

// timebase: one millisecond in ns, clock period in ns
`define SNP_MS_NS 1000000
`define SNP_PCLK_NS 100
`define SNP_CYC_PER_MS (`SNP_MS_NS / `SNP_PCLK_NS)

`endif

// ===== snp_pkg.sv
// types shared by the serial-to-network packer and its bench
// assumes snp_cfg.svh for all numeric constants
package snp_pkg;

    // packer sequencing: collecting serial bytes or draining one packet
    typedef enum logic [0:0] {
        SNP_COLLECT,
        SNP_SEND
    } snp_state_type;

    // one byte on the network side, last marks the end of a packet
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } snp_net_beat_type;

endpackage

// ===== snp_packer.sv
// serial-to-network packer: buffers serial bytes and releases them as
// network packets on time, size or character delimiters, and guards a
// single network connection with an inactivity close timer.
// assumes one clock pclk, apb register access, synchronous data inputs.
//
// Function
// - an open connection idle for the inactivity time is closed by the block.
// - an inactivity time of zero keeps the connection open until a close command.
// - while a peer holds the connection every other peer is refused.
// - after an inactivity close the block waits for and accepts a new peer.
// - with all delimiters zero each serial byte is sent out at once.
// - a nonzero time delimiter sends the buffer that long after the last byte.
// - no packet is ever sent while the buffer is empty.
// - a nonzero size delimiter sends a packet when the buffer reaches the size.
// - bytes past the size stay buffered and each size packet holds exactly the size.
// - the delimiter byte sends every byte before it and is itself dropped.
// - any one enabled delimiter is enough to send a packet.
// - bytes meeting no enabled condition stay buffered unsent.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "snp_cfg.svh"

module snp_packer #(
    parameter int DEPTH = 256,
    parameter int CYC_PER_MS = `SNP_CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial byte stream in
    input wire logic ser_valid,
    input wire logic [7:0] ser_data,
    output logic ser_ready,
    // network byte stream out
    output logic net_valid,
    output snp_pkg::snp_net_beat_type net_beat,
    input wire logic net_ready,
    // connection control
    input wire logic peer_req,
    input wire logic close_cmd,
    input wire logic net_activity,
    output logic peer_accept,
    output logic peer_refuse,
    output logic conn_open,
    output logic irq
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // refused at elaboration: pointers wrap by power of two, count must fit the status field
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || DEPTH > 65535 || CYC_PER_MS < 1)
        begin : g_bad_param
            $error("snp_packer: DEPTH must be a power of two below 65536, CYC_PER_MS above 0");
        end
    endgenerate

    snp_pkg::snp_state_type state_q;
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] left_q;
    logic [15:0] pack_time_q;
    logic [15:0] pack_size_q;
    logic [7:0] pack_char_q;
    logic [15:0] inact_time_q;
    logic [3:0] int_stat_q;
    logic [3:0] int_mask_q;
    logic [31:0] prdata_q;
    logic [31:0] ms_cnt_q;
    logic ms_tick;
    logic [15:0] idle_ms_q;
    logic [15:0] inact_ms_q;
    logic char_hit_q;
    logic conn_q;
    logic accept_q;
    logic refuse_q;
    logic inact_close;
    logic is_char;
    logic ser_take;
    logic char_take;
    logic net_take;
    logic pkt_done;
    logic fire;
    logic [CW-1:0] fire_len;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [3:0] ev_set;

    // apb decode; zero wait states, unmapped addresses answer with pslverr
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    always_comb
    begin
        unique case (paddr)
            `SNP_PACK_TIME_ADDR, `SNP_PACK_SIZE_ADDR, `SNP_PACK_CHAR_ADDR,
            `SNP_INACT_TIME_ADDR, `SNP_STATUS_ADDR, `SNP_INT_STAT_ADDR,
            `SNP_INT_MASK_ADDR: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = prdata_q;

    // configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pack_time_q <= `SNP_PACK_TIME_RST;
            pack_size_q <= `SNP_PACK_SIZE_RST;
            pack_char_q <= `SNP_PACK_CHAR_RST;
            inact_time_q <= `SNP_INACT_TIME_RST;
            int_mask_q <= `SNP_INT_MASK_RST;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                `SNP_PACK_TIME_ADDR: pack_time_q <= pwdata[15:0];
                `SNP_PACK_SIZE_ADDR: pack_size_q <= pwdata[15:0];
                `SNP_PACK_CHAR_ADDR: pack_char_q <= pwdata[7:0];
                `SNP_INACT_TIME_ADDR: inact_time_q <= pwdata[15:0];
                `SNP_INT_MASK_ADDR: int_mask_q <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // read data captured in the setup cycle, stable through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            prdata_q <= 32'h0000_0000;
            unique case (paddr)
                `SNP_PACK_TIME_ADDR: prdata_q[15:0] <= pack_time_q;
                `SNP_PACK_SIZE_ADDR: prdata_q[15:0] <= pack_size_q;
                `SNP_PACK_CHAR_ADDR: prdata_q[7:0] <= pack_char_q;
                `SNP_INACT_TIME_ADDR: prdata_q[15:0] <= inact_time_q;
                `SNP_STATUS_ADDR:
                begin
                    prdata_q[`SNP_STAT_CONN_BIT] <= conn_q;
                    prdata_q[`SNP_STAT_SEND_BIT] <= (state_q == snp_pkg::SNP_SEND);
                    prdata_q[`SNP_STAT_COUNT_LSB +: CW] <= count_q;
                end
                `SNP_INT_STAT_ADDR: prdata_q[3:0] <= int_stat_q;
                `SNP_INT_MASK_ADDR: prdata_q[3:0] <= int_mask_q;
                default: ;
            endcase
        end
    end

    // sticky events, write one to clear; a new event wins over the clear
    assign ev_set[`SNP_EV_PKT_BIT] = pkt_done;
    assign ev_set[`SNP_EV_ACCEPT_BIT] = peer_req & ~conn_q;
    assign ev_set[`SNP_EV_REFUSE_BIT] = peer_req & conn_q;
    assign ev_set[`SNP_EV_INACT_BIT] = inact_close;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_stat_q <= 4'h0;
        end
        else
        begin
            int_stat_q <= (int_stat_q & ~((wr_en && paddr == `SNP_INT_STAT_ADDR)
                ? pwdata[3:0] : 4'h0)) | ev_set;
        end
    end
    assign irq = |(int_stat_q & int_mask_q);

    // millisecond timebase shared by both timers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ms_cnt_q <= 32'h0000_0000;
        end
        else if (ms_tick)
        begin
            ms_cnt_q <= 32'h0000_0000;
        end
        else
        begin
            ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
        end
    end
    assign ms_tick = (ms_cnt_q == 32'(CYC_PER_MS - 1));

    // serial input; stalled while a packet drains so delimiters stay exact
    assign is_char = (pack_char_q != 8'h00) && (ser_data == pack_char_q);
    assign ser_ready = (state_q == snp_pkg::SNP_COLLECT) && ~char_hit_q
        && (count_q != CW'(DEPTH));
    assign ser_take = ser_valid & ser_ready & ~is_char;
    assign char_take = ser_valid & ser_ready & is_char;

    always_ff @(posedge pclk)
    begin
        if (ser_take)
        begin
            mem[wr_q] <= ser_data;
        end
    end

    // time since the last serial byte, in saturating milliseconds
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_ms_q <= 16'h0000;
        end
        else if (ser_take || char_take)
        begin
            idle_ms_q <= 16'h0000;
        end
        else if (ms_tick && idle_ms_q != 16'hffff)
        begin
            idle_ms_q <= idle_ms_q + 16'h0001;
        end
    end

    // delimiter triggers, or-ed; each needs a nonempty buffer
    always_comb
    begin
        fire = 1'b0;
        fire_len = count_q;
        if (count_q != '0)
        begin
            if (char_hit_q)
            begin
                fire = 1'b1;
            end
            else if (pack_size_q != 16'h0000 && 16'(count_q) >= pack_size_q)
            begin
                fire = 1'b1;
                fire_len = CW'(pack_size_q);
            end
            else if (pack_time_q != 16'h0000 && idle_ms_q >= pack_time_q)
            begin
                fire = 1'b1;
            end
            else if (pack_time_q == 16'h0000 && pack_size_q == 16'h0000
                && pack_char_q == 8'h00)
            begin
                fire = 1'b1;
            end
        end
    end
    // otherwise bytes simply stay buffered

    // packet sequencing and buffer pointers
    assign net_take = net_valid & net_ready;
    assign pkt_done = net_take && left_q == CW'(1);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= snp_pkg::SNP_COLLECT;
            left_q <= '0;
            char_hit_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                snp_pkg::SNP_COLLECT:
                begin
                    char_hit_q <= char_take;
                    if (fire)
                    begin
                        state_q <= snp_pkg::SNP_SEND;
                        left_q <= fire_len;
                    end
                end
                snp_pkg::SNP_SEND:
                begin
                    if (net_take)
                    begin
                        left_q <= left_q - CW'(1);
                    end
                    if (pkt_done)
                    begin
                        state_q <= snp_pkg::SNP_COLLECT;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (ser_take)
            begin
                wr_q <= wr_q + AW'(1);
            end
            if (net_take)
            begin
                rd_q <= rd_q + AW'(1);
            end
            // leftover past a size packet stays counted
            count_q <= count_q + CW'(ser_take) - CW'(net_take);
        end
    end

    assign net_valid = (state_q == snp_pkg::SNP_SEND);
    assign net_beat.data = mem[rd_q];
    assign net_beat.last = (left_q == CW'(1));

    // single connection: one peer at a time, closed on idle or command
    assign inact_close = conn_q && inact_time_q != 16'h0000
        && inact_ms_q >= inact_time_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conn_q <= 1'b0;
            accept_q <= 1'b0;
            refuse_q <= 1'b0;
        end
        else
        begin
            accept_q <= peer_req & ~conn_q;
            refuse_q <= peer_req & conn_q;
            if (peer_req && !conn_q)
            begin
                conn_q <= 1'b1;
            end
            else if (close_cmd || inact_close)
            begin
                conn_q <= 1'b0;
            end
        end
    end
    assign peer_accept = accept_q;
    assign peer_refuse = refuse_q;
    assign conn_open = conn_q;

    // inactivity time, restarted by any data moved on the connection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inact_ms_q <= 16'h0000;
        end
        else if (!conn_q || net_activity || net_take)
        begin
            inact_ms_q <= 16'h0000;
        end
        else if (ms_tick && inact_ms_q != 16'hffff)
        begin
            inact_ms_q <= inact_ms_q + 16'h0001;
        end
    end

endmodule // snp_packer

// ===== snp_packer_checker.sv
// port assertions for the serial-to-network packer
// assumes one clock pclk and apb writes visible at the ports
`timescale 1ns/1ps
`include "snp_cfg.svh"
module snp_packer_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ser_valid,
    input wire logic [7:0] ser_data,
    input wire logic ser_ready,
    input wire logic net_valid,
    input wire snp_pkg::snp_net_beat_type net_beat,
    input wire logic net_ready,
    input wire logic peer_req,
    input wire logic close_cmd,
    input wire logic peer_accept,
    input wire logic peer_refuse,
    input wire logic conn_open
);
    logic [2:0] nz_q;
    logic [7:0] chr_q;
    logic [9:0] cnt_q;
    logic keep;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // delimiter enables snooped off the bus, registers are not visible
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            nz_q <= 3'h0;
        else if (psel && penable && pwrite && pready)
        begin
            if (paddr == `SNP_PACK_TIME_ADDR)
                nz_q[0] <= |pwdata[15:0];
            if (paddr == `SNP_PACK_SIZE_ADDR)
                nz_q[1] <= |pwdata[15:0];
            if (paddr == `SNP_PACK_CHAR_ADDR)
                nz_q[2] <= |pwdata[7:0];
        end
    // buffered byte count rebuilt from the ports; a delimiter byte is never stored
    assign keep = ser_valid && ser_ready && !(chr_q != 8'h00 && ser_data == chr_q);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chr_q <= 8'h00;
            cnt_q <= 10'h000;
        end
        else
        begin
            if (psel && penable && pwrite && pready && paddr == `SNP_PACK_CHAR_ADDR)
            begin
                chr_q <= pwdata[7:0];
            end
            cnt_q <= cnt_q + 10'(keep) - 10'(net_valid && net_ready);
        end
    end
    a_accept_free: assert property (peer_req && !conn_open |=> peer_accept && conn_open)
        else $error("free link did not accept");
    a_refuse_held: assert property (peer_req && conn_open |=> peer_refuse && !peer_accept)
        else $error("held link did not refuse");
    a_open_cause: assert property ($rose(conn_open) |-> $past(peer_req))
        else $error("link opened without a peer");
    a_close_cmd: assert property (conn_open && close_cmd && !peer_req |=> !conn_open)
        else $error("close command ignored");
    a_send_direct: assert property (nz_q == 3'h0 && cnt_q == 10'h000 &&
        ser_valid && ser_ready |-> ##2 net_valid && net_beat.last &&
        net_beat.data == $past(ser_data, 2))
        else $error("byte not sent at once");
    a_no_empty_send: assert property (net_valid |-> cnt_q != 10'h000)
        else $error("packet sent from empty buffer");
    a_beat_hold: assert property (net_valid && !net_ready |=> net_valid && $stable(net_beat))
        else $error("beat changed before taken");
    a_no_take_send: assert property (net_valid |-> !ser_ready)
        else $error("serial taken while sending");
    a_last_gap: assert property (net_valid && net_ready && net_beat.last |=> !net_valid)
        else $error("no gap after packet");
    a_bad_addr: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access not flagged");
    c_refuse: cover property (peer_req && conn_open);
    c_packet: cover property (net_valid && net_ready && net_beat.last);
    c_direct: cover property (nz_q == 3'h0 && ser_valid && ser_ready);
endmodule // snp_packer_checker

bind snp_packer snp_packer_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .ser_valid(ser_valid), .ser_data(ser_data), .ser_ready(ser_ready),
    .net_valid(net_valid), .net_beat(net_beat), .net_ready(net_ready), .peer_req(peer_req),
    .close_cmd(close_cmd), .peer_accept(peer_accept), .peer_refuse(peer_refuse),
    .conn_open(conn_open));

// ===== snp_net_sink.sv
// network-side peer: takes packet beats and logs them as text
// assumes the packer's net_valid / net_ready handshake
`timescale 1ns/1ps
module snp_net_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic net_valid,
    input wire snp_pkg::snp_net_beat_type net_beat,
    output logic net_ready
);
    logic [1:0] ph_q;
    string s = "";
    // a slow peer takes one beat in four, so beats must hold
    assign net_ready = !stall || ph_q == 2'h0;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ph_q <= 2'h0;
        else
            ph_q <= ph_q + 2'h1;
    // log each taken byte, a bar after a packet's last
    always @(posedge pclk)
        if (net_valid && net_ready)
            s <= $sformatf(net_beat.last ? "%s%c|" : "%s%c", s, net_beat.data);
endmodule // snp_net_sink

// ===== serial_to_net_packer_tb_top.sv
// self-checking bench for the serial-to-network packer
// assumes snp_net_sink as network peer and 10 cycles to the millisecond
`timescale 1ns/1ps
module serial_to_net_packer_tb_top;
    typedef struct {logic [7:0] a; logic [31:0] v; logic e;} snp_row_type;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00, ser_data = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, ser_valid = 1'h0, ser_ready, net_valid, net_ready, er;
    logic peer_req = 1'h0, close_cmd = 1'h0, net_activity = 1'h0, stall = 1'h1;
    logic peer_accept, peer_refuse, conn_open, irq;
    snp_pkg::snp_net_beat_type net_beat;
    int n_fail = 0, tests_run = 0, cyc = 0, i;
    snp_row_type rows[8] = '{'{8'h00, 32'hffff, 1'h0}, '{8'h04, 32'hffff, 1'h0},
        '{8'h08, 32'hff, 1'h0}, '{8'h0c, 32'hffff, 1'h0}, '{8'h10, 32'h0, 1'h0},
        '{8'h14, 32'h0, 1'h0}, '{8'h18, 32'hf, 1'h0}, '{8'h1c, 32'h0, 1'h1}};

    snp_packer #(.CYC_PER_MS(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ser_valid(ser_valid), .ser_data(ser_data),
        .ser_ready(ser_ready), .net_valid(net_valid), .net_beat(net_beat),
        .net_ready(net_ready), .peer_req(peer_req), .close_cmd(close_cmd),
        .net_activity(net_activity), .peer_accept(peer_accept), .peer_refuse(peer_refuse),
        .conn_open(conn_open), .irq(irq));
    snp_net_sink sink (.pclk(pclk), .presetn(presetn), .stall(stall),
        .net_valid(net_valid), .net_beat(net_beat), .net_ready(net_ready));

    initial
        forever #50 pclk = ~pclk;
    // hang guard, well above the whole run
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic ck(input bit ok, input string m);
        tests_run++;
        if (!ok)
        begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    // one apb transfer, read data left in rd and er
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    // valid stays up across bytes so it is never driven twice in a step
    task automatic ser(input string t);
        for (int k = 0; k < t.len(); k++)
        begin
            ser_valid <= 1'h1;
            ser_data <= t[k];
            do
                @(posedge pclk);
            while (ser_ready !== 1'h1);
        end
        ser_valid <= 1'h0;
        @(posedge pclk);
    endtask

    // an empty expectation waits the whole limit for strays
    task automatic pk(input string e, input int lim);
        for (int k = 0; k < lim && (sink.s.len() < e.len() || e == ""); k++)
            @(posedge pclk);
        ck(sink.s == e, {"packets ", sink.s});
        sink.s = "";
    endtask

    task automatic peer(input logic acc);
        peer_req <= 1'h1;
        @(posedge pclk);
        peer_req <= 1'h0;
        @(posedge pclk);
        ck(peer_accept === acc && peer_refuse === !acc && conn_open === 1'h1, "peer");
    endtask

    task automatic print_verdict;
        $display("tests_run %0d n_fail %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        ck(conn_open === 1'h0 && net_valid === 1'h0 && irq === 1'h0, "reset outputs");
        // reset values, write masks, read-only and unmapped places
        foreach (rows[j])
        begin
            apb(1'h0, rows[j].a, 32'h0);
            ck(rd === 32'h0 && er === rows[j].e, "reset value");
            apb(1'h1, rows[j].a, 32'hffffffff);
            apb(1'h0, rows[j].a, 32'h0);
            ck(rd === rows[j].v, "readback");
            apb(1'h1, rows[j].a, 32'h0);
        end
        ser("AB");
        pk("A|B|", 100);
        apb(1'h1, 8'h04, 32'ha);
        apb(1'h1, 8'h08, 32'hd);
        ser("0123456789abc");
        pk("0123456789|", 200);
        pk("", 100);
        apb(1'h0, 8'h10, 32'h0);
        ck(rd === 32'h0003_0000, "status count");
        ser("\015");
        pk("abc|", 100);
        ser("xy\015z");
        pk("xy|", 100);
        // time joins size and char; z then q wait for the idle time
        apb(1'h1, 8'h00, 32'h3);
        ser("q");
        pk("", 12);
        pk("zq|", 60);
        pk("", 100);
        peer(1'h1);
        peer(1'h0);
        ck(irq === 1'h0, "masked irq");
        apb(1'h1, 8'h18, 32'hf);
        ck(irq === 1'h1, "irq raised");
        apb(1'h0, 8'h14, 32'h0);
        ck(rd === 32'h7, "event bits");
        apb(1'h1, 8'h14, 32'h7);
        ck(irq === 1'h0, "irq cleared");
        // keepalive traffic, then idleness closes the link
        apb(1'h1, 8'h0c, 32'h2);
        for (i = 0; i < 12; i++)
        begin
            net_activity <= 1'h1;
            @(posedge pclk);
            net_activity <= 1'h0;
            repeat (4) @(posedge pclk);
        end
        ck(conn_open === 1'h1, "kept open");
        for (i = 0; i < 60 && conn_open === 1'h1; i++)
            @(posedge pclk);
        ck(conn_open === 1'h0 && i > 4, "idle close");
        apb(1'h0, 8'h14, 32'h0);
        ck(rd === 32'h8, "close event");
        peer(1'h1);
        apb(1'h0, 8'h10, 32'h0);
        ck(rd === 32'h1, "status link");
        apb(1'h1, 8'h0c, 32'h0);
        repeat (60) @(posedge pclk);
        ck(conn_open === 1'h1, "held open");
        close_cmd <= 1'h1;
        @(posedge pclk);
        close_cmd <= 1'h0;
        @(posedge pclk);
        ck(conn_open === 1'h0, "closed");
        // mid-run reset with a byte buffered: buffer and settings must be gone
        ser("k");
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        ck(net_valid === 1'h0 && conn_open === 1'h0 && irq === 1'h0, "mid reset");
        pk("", 60);
        apb(1'h0, 8'h04, 32'h0);
        ck(rd === 32'h0, "size after reset");
        print_verdict();
    end
endmodule // serial_to_net_packer_tb_top
